// ---- verilog/cmp_ctrl_pkg.sv ----
// package: register map, field layout and timing constants for comparator control
package cmp_ctrl_pkg;
    // ==========================================================
    // register byte addresses
    localparam logic [7:0] addr_cmp_one = 8'h00;   // comparator one control
    localparam logic [7:0] addr_cmp_two = 8'h04;   // comparator two control
    localparam logic [7:0] addr_p0_dis = 8'h08;    // port0 input disable
    localparam logic [7:0] addr_irq_en = 8'h0c;    // per-comparator enables + global
    localparam logic [7:0] addr_status = 8'h10;    // sticky event status, w1c
    localparam logic [7:0] addr_mask = 8'h14;      // status mask
    localparam logic [7:0] addr_misc = 8'h18;      // timing select, power mode
    localparam logic [7:0] addr_port0 = 8'h1c;     // port0 read value
    // ==========================================================
    // comparator control field positions
    localparam int f_flag = 0;      // change flag
    localparam int f_result = 1;    // comparator result, read only
    localparam int f_oe = 2;        // result pin enable
    localparam int f_neg = 3;       // negative input select
    localparam int f_pos = 4;       // positive input select
    localparam int f_en = 5;        // comparator enable
    // irq enable register fields
    localparam int f_ec1 = 0;
    localparam int f_ec2 = 1;
    localparam int f_ea = 7;
    // misc register fields
    localparam int f_std = 0;       // standard timing select
    localparam int f_idle = 1;
    localparam int f_pd = 2;
    // ==========================================================
    // reset values
    localparam logic [7:0] rst_byte = 8'h00;
    localparam logic [1:0] rst_two = 2'h0;
    // ==========================================================
    // timing
    localparam int clk_mhz = 100;
    localparam int startup_us = 10;
    localparam int startup_cycles = startup_us * clk_mhz;   // 1000 cycles
    localparam logic [3:0] mc_fast = 4'h6;   // osc periods per machine cycle
    localparam logic [3:0] mc_std = 4'hc;
endpackage : cmp_ctrl_pkg

// ---- verilog/comparator_control_and_irq.sv ----
// comparator control, port0 input disable, change flags and interrupt logic
//
// Contract
// - machine cycle is six oscillator periods
// - standard timing stretches cycle to twelve
// - one input disable bit per port0 pin
// - disabled port0 pins read as zero
// - result one when positive exceeds negative
// - result readable and optionally driven out
// - eight configurations from three select fields
// - change flag set on any output toggle once settled
// - irq needs flag, enable and global enable, or an unmasked status bit
// - comparators keep working in idle, power-down
// - enabled change interrupt wakes the processor
// - result unstable ten microseconds after enable
`timescale 1ns/1ps
module comparator_control_and_irq
    import cmp_ctrl_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [1:0] cmp_raw,          // analog: pos>neg for each comparator
    input wire logic [7:0] port0_pins,       // port0 pin levels
    output logic [1:0] cmp_enable,           // analog block power enables
    output logic [1:0] pos_sel,              // positive input select per comparator
    output logic [1:0] neg_sel,              // negative input select per comparator
    output logic [1:0] result_pin,           // result driven to pins
    output logic [1:0] result_pin_oe,        // pin drive enable
    output logic [7:0] port0_input_disable,  // digital input path off per pin
    output logic [7:0] port0_read,           // port0 value seen by instructions
    output logic cmp_irq,                    // interrupt level
    output logic wake_req,                   // wake from idle/power-down
    output logic machine_tick                // one pulse per machine cycle
);
    // ==========================================================
    // synchronisers for analog results and port pins
    logic [1:0] cs1_reg, cs2_reg, cs3_reg;   // comparator sync chain
    logic [7:0] ps1_reg, ps2_reg, ps3_reg;   // port sync chain
    logic [1:0] cres_reg, cres_next;         // debounced comparator result
    logic [7:0] pval_reg, pval_next;         // debounced port value
    // accepted once stages two and three agree; a split pair keeps the old value
    always_comb begin
        cres_next = (cs3_reg & ~(cs2_reg ^ cs3_reg)) | (cres_reg & (cs2_reg ^ cs3_reg));
        pval_next = (ps3_reg & ~(ps2_reg ^ ps3_reg)) | (pval_reg & (ps2_reg ^ ps3_reg));
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs1_reg <= rst_two;
            cs2_reg <= rst_two;
            cs3_reg <= rst_two;
            ps1_reg <= rst_byte;
            ps2_reg <= rst_byte;
            ps3_reg <= rst_byte;
            cres_reg <= rst_two;
            pval_reg <= rst_byte;
        end else begin
            cs1_reg <= cmp_raw;
            cs2_reg <= cs1_reg;
            cs3_reg <= cs2_reg;
            ps1_reg <= port0_pins;
            ps2_reg <= ps1_reg;
            ps3_reg <= ps2_reg;
            cres_reg <= cres_next;
            pval_reg <= pval_next;
        end
    end

    // ==========================================================
    // ahb-lite slave: zero wait states, always okay
    logic aphase_reg, aphase_next;    // data phase pending
    logic awr_reg, awr_next;          // pending is a write
    logic [7:0] aaddr_reg, aaddr_next;
    logic [31:0] rdata_reg, rdata_next;

    // configuration state
    logic [1:0] en_reg, en_next;        // comparator enables
    logic [1:0] pos_reg, pos_next, neg_reg, neg_next, oe_reg, oe_next;  // input and pin selects
    logic [1:0] flag_reg, flag_next;    // change flags
    logic [1:0] ec_reg, ec_next;        // per-comparator irq enables
    logic ea_reg, ea_next;              // global irq enable
    logic [7:0] dis_reg, dis_next;      // port0 input disable
    logic [1:0] status_reg, status_next;  // sticky wrapper status
    logic [1:0] mask_reg, mask_next;
    logic std_reg, std_next, idle_reg, idle_next, pd_reg, pd_next;  // timing and power modes
    logic [1:0] cprev_reg;              // last result for edge detection
    logic [9:0] settle_reg [2];         // start-up timers
    logic [9:0] settle_next [2];
    logic [1:0] stable;                 // settled, results trusted

    // compose a comparator control byte
    function automatic logic [31:0] ctl_word(input int i);
        logic [31:0] w;
        w = 32'h0;
        w[f_flag] = flag_reg[i];
        w[f_result] = cres_reg[i];
        w[f_oe] = oe_reg[i];
        w[f_neg] = neg_reg[i];
        w[f_pos] = pos_reg[i];
        w[f_en] = en_reg[i];
        return w;
    endfunction : ctl_word
    logic wr_go;
    logic [1:0] change;   // trusted output toggle per comparator
    assign wr_go = aphase_reg && awr_reg;
    // edge detection is held off until the comparator has settled
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            stable[i] = en_reg[i] && (settle_reg[i] == 10'(startup_cycles));
            change[i] = stable[i] && (cres_reg[i] != cprev_reg[i]);
        end
    end
    // register file next state
    always_comb begin
        aphase_next = hsel && hready && htrans[1];
        awr_next = hwrite;
        aaddr_next = haddr;
        rdata_next = 32'h0;
        en_next = en_reg;
        pos_next = pos_reg;
        neg_next = neg_reg;
        oe_next = oe_reg;
        flag_next = flag_reg;
        ec_next = ec_reg;
        ea_next = ea_reg;
        dis_next = dis_reg;
        status_next = status_reg;
        mask_next = mask_reg;
        std_next = std_reg;
        idle_next = idle_reg;
        pd_next = pd_reg;
        // read data decode on the address phase
        if (haddr == addr_cmp_one) begin
            rdata_next = ctl_word(0);
        end else if (haddr == addr_cmp_two) begin
            rdata_next = ctl_word(1);
        end else if (haddr == addr_p0_dis) begin
            rdata_next = {24'h0, dis_reg};
        end else if (haddr == addr_irq_en) begin
            rdata_next = {24'h0, ea_reg, 5'h0, ec_reg};
        end else if (haddr == addr_status) begin
            rdata_next = {30'h0, status_reg};
        end else if (haddr == addr_mask) begin
            rdata_next = {30'h0, mask_reg};
        end else if (haddr == addr_misc) begin
            rdata_next = {29'h0, pd_reg, idle_reg, std_reg};
        end else if (haddr == addr_port0) begin
            rdata_next = {24'h0, pval_reg & ~dis_reg};
        end
        // writes in the data phase
        if (wr_go) begin
            if (aaddr_reg == addr_cmp_one || aaddr_reg == addr_cmp_two) begin
                for (int i = 0; i < 2; i++) begin
                    if (aaddr_reg == (i == 0 ? addr_cmp_one : addr_cmp_two)) begin
                        en_next[i] = hwdata[f_en];
                        pos_next[i] = hwdata[f_pos];
                        neg_next[i] = hwdata[f_neg];
                        oe_next[i] = hwdata[f_oe];
                        if (!hwdata[f_flag]) begin
                            flag_next[i] = 1'b0;
                        end
                    end
                end
            end else if (aaddr_reg == addr_p0_dis) begin
                dis_next = hwdata[7:0];
            end else if (aaddr_reg == addr_irq_en) begin
                ec_next = hwdata[1:0];
                ea_next = hwdata[f_ea];
            end else if (aaddr_reg == addr_status) begin
                status_next = status_reg & ~hwdata[1:0];
            end else if (aaddr_reg == addr_mask) begin
                mask_next = hwdata[1:0];
            end else if (aaddr_reg == addr_misc) begin
                std_next = hwdata[f_std];
                idle_next = hwdata[f_idle];
                pd_next = hwdata[f_pd];
            end
        end
        flag_next = flag_next | change;
        status_next = status_next | change;
        // timer restarts whenever disabled, stops once settled
        for (int i = 0; i < 2; i++) begin
            settle_next[i] = en_reg[i] ? (settle_reg[i] + 10'(!stable[i])) : 10'h0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aphase_reg <= 1'b0;
            awr_reg <= 1'b0;
            aaddr_reg <= rst_byte;
            rdata_reg <= 32'h0;
            en_reg <= rst_two;
            pos_reg <= rst_two;
            neg_reg <= rst_two;
            oe_reg <= rst_two;
            flag_reg <= rst_two;
            ec_reg <= rst_two;
            ea_reg <= 1'b0;
            dis_reg <= rst_byte;
            status_reg <= rst_two;
            mask_reg <= rst_two;
            std_reg <= 1'b0;
            idle_reg <= 1'b0;
            pd_reg <= 1'b0;
            cprev_reg <= rst_two;
            settle_reg <= '{default: 10'h0};
        end else begin
            aphase_reg <= aphase_next;
            awr_reg <= awr_next;
            aaddr_reg <= aaddr_next;
            rdata_reg <= rdata_next;
            en_reg <= en_next;
            pos_reg <= pos_next;
            neg_reg <= neg_next;
            oe_reg <= oe_next;
            flag_reg <= flag_next;
            ec_reg <= ec_next;
            ea_reg <= ea_next;
            dis_reg <= dis_next;
            status_reg <= status_next;
            mask_reg <= mask_next;
            std_reg <= std_next;
            idle_reg <= idle_next;
            pd_reg <= pd_next;
            // unsettled results are tracked so no stale toggle fires later
            cprev_reg <= cres_reg;
            settle_reg <= settle_next;
        end
    end
    // ==========================================================
    // machine cycle divider
    logic [3:0] mc_reg, mc_next;    // position within the machine cycle
    logic tick_reg, tick_next;
    always_comb begin
        if (mc_reg >= ((std_reg ? mc_std : mc_fast) - 4'h1)) begin
            mc_next = 4'h0;
            tick_next = 1'b1;
        end else begin
            mc_next = mc_reg + 4'h1;
            tick_next = 1'b0;
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mc_reg <= 4'h0;
            tick_reg <= 1'b0;
        end else begin
            mc_reg <= mc_next;
            tick_reg <= tick_next;
        end
    end
    // ==========================================================
    // registered outputs
    logic irq_reg, irq_next, wake_reg, wake_next;
    logic [1:0] rpin_reg, rpin_next, roe_reg, roe_next;
    logic [7:0] pread_reg, pread_next;
    always_comb begin
        // flag, own enable and global enable, or unmasked status
        irq_next = (|(flag_next & ec_next) && ea_next) || |(status_next & mask_next);
        // wake only in a low power mode
        wake_next = (idle_next || pd_next) && |(flag_next & ec_next) && ea_next;
        // result comes from pos greater than neg
        rpin_next = cres_next & oe_next & en_next;
        roe_next = oe_next & en_next;
        pread_next = pval_next & ~dis_next;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_reg <= 1'b0;
            wake_reg <= 1'b0;
            rpin_reg <= rst_two;
            roe_reg <= rst_two;
            pread_reg <= rst_byte;
        end else begin
            irq_reg <= irq_next;
            wake_reg <= wake_next;
            rpin_reg <= rpin_next;
            roe_reg <= roe_next;
            pread_reg <= pread_next;
        end
    end
    assign hrdata = rdata_reg;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign cmp_enable = en_reg;
    assign pos_sel = pos_reg;
    assign neg_sel = neg_reg;
    assign result_pin = rpin_reg;
    assign result_pin_oe = roe_reg;
    assign port0_input_disable = dis_reg;
    assign port0_read = pread_reg;
    assign cmp_irq = irq_reg;
    assign wake_req = wake_reg;
    assign machine_tick = tick_reg;
    // ==========================================================
    // checks
    flag_sticky_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (change[0] |=> flag_reg[0])) else $error("change flag not set after toggle");
    irq_gate_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (flag_reg[0] && ec_reg[0] && ea_reg |-> irq_reg)) else $error("irq missing");
    p0_zero_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ((port0_read & dis_reg) == 8'h0)) else $error("disabled pin read nonzero");
    settle_hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(en_reg[0]) |-> !change[0] [*8])) else $error("change during start-up");
    tick_fast_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ((tick_reg && !std_reg) ##1 (!tick_reg && !std_reg) [*5] |=> tick_reg))
        else $error("machine cycle not six");
    tick_std_a: assert property (@(posedge hclk) disable iff (!hresetn)
        ((tick_reg && std_reg) ##1 (!tick_reg && std_reg) [*8] ##1 (!tick_reg && std_reg) [*3]
        |=> tick_reg)) else $error("machine cycle not twelve");
    pin_route_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (!roe_reg[0] |-> !result_pin[0])) else $error("result pin driven while off");
    wake_mode_a: assert property (@(posedge hclk) disable iff (!hresetn)
        (wake_reg |-> idle_reg || pd_reg)) else $error("wake outside low power");
endmodule : comparator_control_and_irq

// ---- verif/comparator_analog_model.sv ----
// analog side model: two comparators fed by pin levels in millivolts
`timescale 1ns/1ps
module comparator_analog_model #(
    parameter int ref_mv = 1280  // internal reference level
) (
    input wire logic [1:0] cmp_enable,
    input wire logic [1:0] pos_sel,
    input wire logic [1:0] neg_sel,
    input wire logic [11:0] pin_mv [0:5],  // pin a, pin b, neg pin per comparator
    output logic [1:0] cmp_raw
);
    // ==========================================
    // comparison core, runs in every power mode
    // pos above neg gives one
    always_comb begin
        for (int n = 0; n < 2; n++) begin
            // a powered-down comparator sits low
            cmp_raw[n] = cmp_enable[n] &&
                ((pos_sel[n] ? pin_mv[3*n+1] : pin_mv[3*n]) >
                 (neg_sel[n] ? 12'(ref_mv) : pin_mv[3*n+2]));
        end
    end
endmodule : comparator_analog_model

// ---- verif/comparator_control_and_irq_tb.sv ----
// testbench for comparator control, port0 disable and interrupts
`timescale 1ns/1ps
module comparator_control_and_irq_tb;
    import cmp_ctrl_pkg::*;
    // ==========================================
    // bench signals
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic [7:0] haddr, port0_pins, port0_input_disable, port0_read;
    logic [1:0] htrans, cmp_raw, cmp_enable, pos_sel, neg_sel;
    logic [1:0] result_pin, result_pin_oe;
    logic [2:0] hsize;
    logic [31:0] hwdata, hrdata, r;
    logic cmp_irq, wake_req, machine_tick;
    logic [11:0] pin_mv [0:5];  // analog levels
    int fail_count = 0;
    int total_checks = 0;
    // single slave: its ready is the bus ready
    assign hready = hreadyout;
    comparator_control_and_irq comparator_control_and_irq_inst (.hclk(hclk),
        .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cmp_raw(cmp_raw),
        .port0_pins(port0_pins), .cmp_enable(cmp_enable), .pos_sel(pos_sel),
        .neg_sel(neg_sel), .result_pin(result_pin), .result_pin_oe(result_pin_oe),
        .port0_input_disable(port0_input_disable), .port0_read(port0_read),
        .cmp_irq(cmp_irq), .wake_req(wake_req), .machine_tick(machine_tick));
    comparator_analog_model comparator_analog_model_inst (.cmp_enable(cmp_enable),
        .pos_sel(pos_sel), .neg_sel(neg_sel), .pin_mv(pin_mv), .cmp_raw(cmp_raw));
    // ==========================================
    // shared tasks
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // one single transfer; waits on ready, never on a fixed count
    task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask : xfer
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(a, 1'b1, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        xfer(a, 1'b0, 32'h0);
        check(r, exp);
        check({31'h0, hresp}, 32'h0);
    endtask : rd_chk
    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
    endtask : tick
    // flip comparator one positive pin across the negative pin level
    task automatic toggle();
        @(posedge hclk);
        pin_mv[0] <= (pin_mv[0] == 12'd2000) ? 12'd500 : 12'd2000;
        tick(10);
    endtask : toggle
    // clear flag and status so the next scenario starts clean
    task automatic clean();
        wr(addr_cmp_one, 32'h20);
        wr(addr_status, 32'h3);
        tick(3);
    endtask : clean
    // ==========================================
    // scenarios
    task automatic t_reset();
        for (int a = 0; a <= 32; a += 4) rd_chk(8'(a), 32'h0);
        wr(8'h20, 32'hff);
        rd_chk(8'h20, 32'h0);
        $display("test reset done");
    endtask : t_reset
    task automatic t_port0();
        port0_pins <= 8'hff;
        wr(addr_p0_dis, 32'h30);
        tick(6);
        check({24'h0, port0_input_disable}, 32'h30);
        check({24'h0, port0_read}, 32'hcf);
        rd_chk(addr_port0, 32'hcf);
        rd_chk(addr_p0_dis, 32'h30);
        wr(addr_p0_dis, 32'h0);
        $display("test port0 done");
    endtask : t_port0
    task automatic t_startup();
        wr(addr_cmp_one, 32'h20);
        tick(200);
        toggle();
        rd_chk(addr_status, 32'h0);
        xfer(addr_cmp_one, 1'b0, 32'h0);
        check({31'h0, r[f_flag]}, 32'h0);
        toggle();
        tick(900);
        $display("test startup done");
    endtask : t_startup
    task automatic t_configs();
        logic p, n, o, res;
        for (int c = 0; c < 8; c++) begin
            {p, n, o} = 3'(c);
            res = ((p ? 1100 : 2000) > (n ? 1280 : 1000));
            // flag written as one so the toggle of config six stays sticky
            wr(addr_cmp_one, 32'h21 | {p, n, o, 2'b0});
            tick(8);
            xfer(addr_cmp_one, 1'b0, 32'h0);
            check({27'h0, r[5:1]}, {27'h0, 1'b1, p, n, o, res});
            check({28'h0, pos_sel[0], neg_sel[0], result_pin_oe[0], result_pin[0]},
                  {28'h0, p, n, o, res & o});
        end
        check({31'h0, r[f_flag]}, 32'h1);
        wr(addr_cmp_one, 32'h20);
        tick(8);
        clean();
        rd_chk(addr_cmp_one, 32'h22);
        $display("test configs done");
    endtask : t_configs
    task automatic t_irq();
        wr(addr_mask, 32'h1);
        toggle();
        check({31'h0, cmp_irq}, 32'h1);
        rd_chk(addr_status, 32'h1);
        tick(50);
        rd_chk(addr_cmp_one, 32'h21);
        wr(addr_status, 32'h1);
        tick(3);
        check({31'h0, cmp_irq}, 32'h0);
        wr(addr_mask, 32'h0);
        toggle();
        check({31'h0, cmp_irq}, 32'h0);
        rd_chk(addr_status, 32'h1);
        wr(addr_irq_en, 32'h1);
        tick(3);
        check({31'h0, cmp_irq}, 32'h0);
        wr(addr_irq_en, 32'h81);
        tick(3);
        check({30'h0, wake_req, cmp_irq}, 32'h1);
        wr(addr_cmp_one, 32'h20);
        tick(3);
        check({31'h0, cmp_irq}, 32'h0);
        clean();
        $display("test irq done");
    endtask : t_irq
    task automatic t_power();
        for (int m = 2; m <= 4; m += 2) begin
            wr(addr_misc, 32'(m));
            toggle();
            check({30'h0, wake_req, cmp_irq}, 32'h3);
            check({30'h0, cmp_enable}, 32'h1);
            clean();
            check({31'h0, wake_req}, 32'h0);
        end
        wr(addr_misc, 32'h0);
        $display("test power done");
    endtask : t_power
    task automatic gap(output int n);
        n = 0;
        do @(posedge hclk); while (machine_tick !== 1'b1);
        do begin
            @(posedge hclk);
            n++;
        end while (machine_tick !== 1'b1);
    endtask : gap
    task automatic t_cycle();
        int n;
        gap(n);
        check(n, 6);
        wr(addr_misc, 32'h1);
        gap(n);
        gap(n);
        check(n, 12);
        wr(addr_misc, 32'h0);
        $display("test cycle done");
    endtask : t_cycle
    // ==========================================
    // ending, shared by main sequence and watchdog
    task automatic conclude();
        $display("checks=%0d failures=%0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : conclude
    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // whole run is under two thousand cycles; cut off well beyond that
    initial begin
        repeat (20000) @(posedge hclk);
        fail_count++;
        $display("watchdog expired");
        conclude();
    end
    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        hsize = 3'h2;
        port0_pins = 8'h00;
        for (int i = 0; i < 6; i += 3) begin
            pin_mv[i] = 12'd2000;
            pin_mv[i+1] = 12'd1100;
            pin_mv[i+2] = 12'd1000;
        end
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_port0();
        t_startup();
        t_configs();
        t_irq();
        t_power();
        t_cycle();
        conclude();
    end
endmodule : comparator_control_and_irq_tb
